// *** inc/eeac_pkg.sv ***
// Shared constants, types and timing for the EEPROM access control block.
package eeac_pkg;
  // Register selects on the core I/O port.
  localparam logic [1:0] SEL_ADDR  = 2'h0;
  localparam logic [1:0] SEL_DATA  = 2'h1;
  localparam logic [1:0] SEL_CTRL  = 2'h2;
  // Control register field positions.
  localparam int         CTL_RD    = 0;
  localparam int         CTL_WS    = 1;
  localparam int         CTL_ARM   = 2;
  localparam int         CTL_RIE   = 3;
  localparam int         CTL_PM_LO = 4;
  localparam int         CTL_PM_HI = 5;
  // Reset values.
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic       RIE_RESET  = 1'b0;
  // Core cycle counts.
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  localparam logic [2:0] WR_STALL   = 3'h2;
  localparam logic [2:0] RD_STALL   = 3'h4;
  // Programming times in microseconds and in oscillator ticks.
  localparam int         PROG_FULL_US    = 3400;
  localparam int         PROG_HALF_US    = 1800;
  localparam int         PROG_FULL_TICKS = 26368;
  localparam int         PROG_HALF_TICKS = PROG_FULL_TICKS * PROG_HALF_US / PROG_FULL_US;

  typedef enum logic [1:0] {
    PM_ATOMIC = 2'b00,
    PM_ERASE  = 2'b01,
    PM_WRITE  = 2'b10,
    PM_RSVD   = 2'b11
  } eeac_pmode_t;

  localparam eeac_pmode_t PM_RESET = PM_ATOMIC;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_PROG = 1'b1
  } eeac_state_t;

  typedef struct packed {
    logic       wr;
    logic [1:0] sel;
    logic [7:0] wdata;
  } eeac_io_req_t;
endpackage

// *** rtl/eeac_top.sv ***
// EEPROM access control: address, data and control registers with timed programming.
`timescale 1ns/1ns
module eeac_top #(
  parameter int DEPTH           = 64,
  parameter int PROG_FULL_TICKS = eeac_pkg::PROG_FULL_TICKS,
  parameter int PROG_HALF_TICKS = eeac_pkg::PROG_HALF_TICKS
) (
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire logic                  clk_en,
  input  wire eeac_pkg::eeac_io_req_t io_req,
  output logic [7:0]                 io_rdata,
  input  wire logic                  global_irq_en,
  input  wire logic                  flash_selfprog_enable,
  input  wire logic                  osc_tick,
  output logic                       ready_irq,
  output logic                       cpu_stall
);
  import eeac_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(PROG_FULL_TICKS + 1);

  if (DEPTH != 64 || PROG_HALF_TICKS < 1 || PROG_FULL_TICKS < PROG_HALF_TICKS) begin : g_chk
    $error("eeac_top: unsupported depth or programming tick counts");
  end

  // The byte array has no reset: stored bytes outlive a reset, as in the real cell array.
  logic [7:0]    mem [DEPTH];
  logic [AW-1:0] byte_address_reg;
  logic [7:0]    byte_data_reg;
  logic [7:0]    prog_data;
  eeac_pmode_t   prog_mode;
  logic          ready_irq_enable;
  logic          rd_pend;
  logic [2:0]    arm_cnt;
  logic [2:0]    stall_cnt;
  logic [CW-1:0] pcnt;
  eeac_state_t   state;
  eeac_state_t   next_state;
  eeac_pmode_t   next_mode;

  wire           ctl_wr        = io_req.wr && (io_req.sel == SEL_CTRL);
  wire           addr_wr       = io_req.wr && (io_req.sel == SEL_ADDR);
  wire           data_wr       = io_req.wr && (io_req.sel == SEL_DATA);
  wire           write_strobe  = (state == ST_PROG);
  wire           master_write_arm = (arm_cnt != 3'h0);
  wire           arm_req       = ctl_wr && io_req.wdata[CTL_ARM] && !io_req.wdata[CTL_WS];
  wire           ws_req        = ctl_wr && io_req.wdata[CTL_WS];
  wire           rd_req        = ctl_wr && io_req.wdata[CTL_RD] && !write_strobe;
  wire           mode_wr       = ctl_wr && !write_strobe;
  assign next_mode = mode_wr ? eeac_pmode_t'(io_req.wdata[CTL_PM_HI:CTL_PM_LO]) : prog_mode;
  // A strobe counts only while armed, idle, with flash idle and a defined mode.
  wire           start         = ws_req && master_write_arm && !write_strobe
                                 && !flash_selfprog_enable
                                 && (next_mode != PM_RSVD);
  wire           prog_done     = write_strobe && osc_tick && (pcnt == CW'(1));
  wire [CW-1:0]  prog_len      = (next_mode == PM_ATOMIC) ? CW'(PROG_FULL_TICKS)
                                                          : CW'(PROG_HALF_TICKS);
  wire [7:0]     cur_byte      = mem[byte_address_reg];
  // Erase leaves all ones; write only can clear bits but never set them.
  wire [7:0]     prog_value    = (prog_mode == PM_ERASE) ? 8'hff :
                                 (prog_mode == PM_WRITE) ? (cur_byte & prog_data) : prog_data;
  wire [7:0]     ctl_read      = {2'h0, prog_mode, ready_irq_enable, master_write_arm, write_strobe, rd_pend};

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = ST_PROG;
        end
      end
      ST_PROG: begin
        if (prog_done) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  assign ready_irq = ready_irq_enable && global_irq_en
                     && !write_strobe && !flash_selfprog_enable;
  assign cpu_stall = (stall_cnt != 3'h0);
  assign io_rdata  = (io_req.sel == SEL_ADDR) ? 8'(byte_address_reg) :
                     (io_req.sel == SEL_DATA) ? byte_data_reg :
                     (io_req.sel == SEL_CTRL) ? ctl_read : 8'h00;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state            <= ST_IDLE;
      prog_mode        <= PM_RESET;
      ready_irq_enable <= RIE_RESET;
      arm_cnt          <= 3'h0;
      stall_cnt        <= 3'h0;
      pcnt             <= '0;
      rd_pend          <= 1'b0;
    end else if (clk_en) begin
      state            <= next_state;
      prog_mode        <= next_mode;
      ready_irq_enable <= ctl_wr ? io_req.wdata[CTL_RIE] : ready_irq_enable;
      arm_cnt          <= arm_req ? ARM_CYCLES : (master_write_arm ? arm_cnt - 3'h1 : 3'h0);
      stall_cnt        <= rd_req ? RD_STALL : (start ? WR_STALL : (cpu_stall ? stall_cnt - 3'h1 : 3'h0));
      pcnt             <= start ? prog_len : ((write_strobe && osc_tick) ? pcnt - CW'(1) : pcnt);
      rd_pend          <= rd_req;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      byte_address_reg <= AW'(ADDR_RESET);
      byte_data_reg    <= DATA_RESET;
      prog_data        <= DATA_RESET;
    end else if (clk_en) begin
      if (addr_wr && !write_strobe) begin
        byte_address_reg <= io_req.wdata[AW-1:0];
      end
      if (rd_pend) begin
        byte_data_reg <= cur_byte;
      end else if (data_wr) begin
        byte_data_reg <= io_req.wdata;
      end
      if (start) begin
        prog_data <= data_wr ? io_req.wdata : byte_data_reg;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (clk_en && prog_done) begin
      mem[byte_address_reg] <= prog_value;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst || !clk_en);

  AST_IRQ_ENABLE: assert property (!ready_irq_enable || !global_irq_en |-> !ready_irq)
    else $error("ready interrupt without enable");
  AST_IRQ_QUIET: assert property (write_strobe || flash_selfprog_enable |-> !ready_irq)
    else $error("ready interrupt while busy");
  AST_START: assert property (start |=> write_strobe && cpu_stall)
    else $error("armed strobe did not start programming");
  AST_NO_ARM: assert property (ws_req && !master_write_arm && !write_strobe |=> !write_strobe)
    else $error("strobe without arm started programming");
  AST_ARM_LIFE: assert property ($rose(master_write_arm) |-> master_write_arm[*4])
    else $error("arm cleared early");
  AST_ARM_EXPIRE: assert property (arm_cnt == 3'h1 && !arm_req |=> !master_write_arm)
    else $error("arm did not expire");
  AST_FLASH_BLOCK: assert property (ws_req && flash_selfprog_enable && !write_strobe |=> !write_strobe)
    else $error("programming during flash self-programming");
  AST_PROG_HOLD: assert property (write_strobe && !prog_done |=> write_strobe)
    else $error("strobe dropped before programming time");
  AST_WR_STALL: assert property (start && !rd_req |=> cpu_stall[*2] ##1 !cpu_stall)
    else $error("write stall not two cycles");
  AST_RD_DATA: assert property (rd_req |=> rd_pend ##1 (byte_data_reg == $past(cur_byte) && !rd_pend))
    else $error("read data not loaded");
  AST_RD_STALL: assert property (rd_req |=> cpu_stall[*4] ##1 !cpu_stall)
    else $error("read stall not four cycles");
  AST_ADDR_HOLD: assert property (write_strobe && $past(write_strobe) |-> $stable(byte_address_reg))
    else $error("address changed while busy");
  AST_MODE_HOLD: assert property (write_strobe && $past(write_strobe) |-> $stable(prog_mode))
    else $error("mode changed while busy");

  // The ready level comes back in the first cycle after programming ends.
  AST_IRQ_LEVEL: assert property ($fell(write_strobe) && ready_irq_enable && global_irq_en && !flash_selfprog_enable |-> ready_irq)
    else $error("ready interrupt missing after programming");
  AST_RIE_WRITE: assert property (ctl_wr |=> ready_irq_enable == $past(io_req.wdata[CTL_RIE]))
    else $error("ready interrupt enable not written");

  AST_RSVD_MODE: assert property (ws_req && !write_strobe && io_req.wdata[CTL_PM_HI:CTL_PM_LO] == 2'h3 |=> !write_strobe)
    else $error("reserved mode started programming");
  AST_LEN_LOAD: assert property (start |=> pcnt == ((prog_mode == PM_ATOMIC) ? CW'(PROG_FULL_TICKS) : CW'(PROG_HALF_TICKS)))
    else $error("programming length does not match mode");
  AST_TICK_HOLD: assert property (write_strobe && !osc_tick |=> $stable(pcnt))
    else $error("programming time advanced without a tick");
  AST_DONE_CLEAR: assert property (prog_done |=> !write_strobe)
    else $error("strobe not cleared after programming time");
  AST_DATA_HOLD: assert property (write_strobe && $past(write_strobe) |-> $stable(prog_data))
    else $error("programming data changed while busy");

  // Each mode leaves in the array the byte that its operation defines.
  AST_ATOMIC_VALUE: assert property (prog_done && prog_mode == PM_ATOMIC |=> cur_byte == $past(prog_data))
    else $error("atomic write stored a wrong byte");
  AST_ERASE_VALUE: assert property (prog_done && prog_mode == PM_ERASE |=> cur_byte == 8'hff)
    else $error("erase did not leave all ones");
  AST_WRITE_VALUE: assert property (prog_done && prog_mode == PM_WRITE |=> cur_byte == ($past(cur_byte) & $past(prog_data)))
    else $error("write only stored a wrong byte");

  // Bus side: refused reads and the address read-back.
  AST_RD_BUSY: assert property (ctl_wr && io_req.wdata[CTL_RD] && write_strobe |=> !rd_pend)
    else $error("read accepted while busy");
  AST_ADDR_READ: assert property (io_req.sel == SEL_ADDR |-> io_rdata[7:6] == 2'h0)
    else $error("address upper bits not zero");

  COV_WRITE: cover property (start ##[1:1000] write_strobe);
  COV_DONE:  cover property (prog_done);
  COV_READ:  cover property (rd_req);
  COV_NOARM: cover property (ws_req && !master_write_arm);
  COV_RSVD:  cover property (ws_req && master_write_arm && next_mode == PM_RSVD);
endmodule // eeac_top

// *** sim/testbench.sv ***
// Self-checking bench for the EEPROM access control block.
`timescale 1ns/1ns
module testbench;
  import eeac_pkg::*;
  logic         core_clk, nrst, clk_en, global_irq_en, flash_selfprog_enable, osc_tick;
  logic         ready_irq, cpu_stall;
  eeac_io_req_t io_req;
  logic [7:0]   io_rdata, v, d, mem [64];
  logic [5:0]   a;
  logic [1:0]   m;
  int           fails, n_tests, k, c, mi;

  eeac_top #(.PROG_FULL_TICKS(16), .PROG_HALF_TICKS(8)) dut (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
    .io_req(io_req), .io_rdata(io_rdata), .global_irq_en(global_irq_en), .osc_tick(osc_tick),
    .flash_selfprog_enable(flash_selfprog_enable), .ready_irq(ready_irq), .cpu_stall(cpu_stall));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Ticks are sparse so that programming outlasts the refusal checks.
  always @(negedge core_clk) osc_tick <= ($urandom % 4) == 0;

  function automatic logic [7:0] exp_byte(input logic [1:0] md, input logic [7:0] o, input logic [7:0] n);
    return md == 2'b00 ? n : md == 2'b01 ? 8'hff : md == 2'b10 ? (o & n) : o;
  endfunction

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic put(input logic [1:0] s, input logic [7:0] w);
    io_req = '{1'b1, s, w};
    @(negedge core_clk);
  endtask

  task automatic rd(input logic [1:0] s);
    io_req = '{1'b0, s, 8'h00};
    #1 v = io_rdata;
  endtask

  // Counts cycles with the arm bit (arm=1) or the stall request (arm=0) high.
  task automatic count(input bit arm);
    c = 0;
    repeat (6) begin
      rd(SEL_CTRL);
      if ((arm ? v[CTL_ARM] : cpu_stall) === 1'b1) c++;
      @(negedge core_clk);
    end
  endtask

  task automatic wait_idle;
    for (k = 0; k < 400; k++) begin
      rd(SEL_CTRL);
      if (v[CTL_WS] === 1'b0) return;
      @(negedge core_clk);
    end
    fails++;
    wrap_up();
  endtask

  initial begin
    k = $urandom(91718);
    {nrst, clk_en, global_irq_en, flash_selfprog_enable} = 4'b0110;
    io_req = '0;
    repeat (2) @(negedge core_clk);
    nrst = 1'b1;
    rd(SEL_CTRL); chk("ctrl reset", 8'h00, v);
    put(SEL_ADDR, 8'hff); rd(SEL_ADDR); chk("addr upper", 8'h3f, v);
    a = 6'($urandom);
    for (mi = 0; mi < 4; mi++) begin
      m = 2'(mi);
      d = 8'($urandom);
      put(SEL_ADDR, {2'b00, a});
      put(SEL_DATA, d);
      put(SEL_CTRL, {2'b00, m, 4'hc});
      put(SEL_CTRL, {2'b00, m, 4'ha});
      rd(SEL_CTRL);
      chk("busy", {2'b00, m, 2'b11, m != 2'b11, 1'b0}, v);
      chk("irq busy", {7'h00, m == 2'b11}, {7'h00, ready_irq});
      count(1'b0); chk("write stall", m == 2'b11 ? 8'h00 : 8'h02, 8'(c));
      if (m != 2'b11) begin
        put(SEL_ADDR, {2'b00, ~a});
        put(SEL_CTRL, 8'h39);
        rd(SEL_CTRL); chk("mode held", {2'b00, m, 4'ha}, v);
        rd(SEL_ADDR); chk("addr held", {2'b00, a}, v);
        rd(SEL_DATA); chk("no read", d, v);
        wait_idle();
        mem[a] = exp_byte(m, mem[a], d);
      end
      put(SEL_CTRL, 8'h09);
      count(1'b0); chk("read stall", 8'h04, 8'(c));
      rd(SEL_DATA); chk("read data", mem[a], v);
      rd(SEL_CTRL); chk("read clear", 8'h08, v);
      $display("mode %0d test done", mi);
    end
    put(SEL_CTRL, 8'h0c); count(1'b1); chk("arm span", 8'h04, 8'(c));
    // With the clock enable low the arm window must not run down.
    put(SEL_CTRL, 8'h0c);
    clk_en = 1'b0;
    repeat (3) @(negedge core_clk);
    clk_en = 1'b1;
    count(1'b1);
    chk("arm frozen", 8'h04, 8'(c));
    put(SEL_CTRL, 8'h0a); rd(SEL_CTRL); chk("no arm", 8'h08, v);
    // Strobe on the fifth edge after arming is refused, on the fourth it starts.
    put(SEL_CTRL, 8'h0c);
    rd(SEL_CTRL);
    repeat (4) @(negedge core_clk);
    put(SEL_CTRL, 8'h0a);
    rd(SEL_CTRL);
    chk("late strobe", 8'h08, v);
    put(SEL_CTRL, 8'h0c);
    rd(SEL_CTRL);
    repeat (3) @(negedge core_clk);
    put(SEL_CTRL, 8'h0a);
    rd(SEL_CTRL);
    chk("edge strobe", 8'h0a, v);
    chk("irq edge", 8'h00, {7'h00, ready_irq});
    wait_idle();
    $display("arm test done");
    flash_selfprog_enable = 1'b1;
    put(SEL_CTRL, 8'h0c); put(SEL_CTRL, 8'h0a);
    rd(SEL_CTRL); chk("flash block", 8'h0c, v);
    chk("irq flash", 8'h00, {7'h00, ready_irq});
    flash_selfprog_enable = 1'b0;
    #1 chk("irq on", 8'h01, {7'h00, ready_irq});
    global_irq_en = 1'b0;
    #1 chk("irq global", 8'h00, {7'h00, ready_irq});
    global_irq_en = 1'b1;
    @(negedge core_clk);
    put(SEL_CTRL, 8'h00); rd(SEL_CTRL); chk("irq off", 8'h00, {7'h00, ready_irq});
    $display("interlock test done");
    put(SEL_CTRL, 8'h20);
    rd(SEL_CTRL);
    chk("mode set", 8'h20, v);
    @(negedge core_clk);
    nrst = 1'b0;
    @(negedge core_clk);
    nrst = 1'b1;
    rd(SEL_CTRL);
    chk("mode reset", 8'h00, v);
    $display("reset test done");
    wrap_up();
  end
endmodule // testbench
